//--- inc/srp_pkg.sv
// Package: register map, field positions, reset values and timing constants
package srp_pkg;

  // ==========================================================
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_PART_ID_HIGH  = 8'h00;
  localparam logic [7:0] ADDR_PART_ID_LOW   = 8'h04;
  localparam logic [7:0] ADDR_WAKEUP_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_LOW_VOLT_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STOP_PWR_CTRL = 8'h10;

  // ==========================================================
  // Wakeup timer control fields
  localparam int WAKEUP_FLAG_BIT  = 7;
  localparam int WAKEUP_CLEAR_BIT = 6;
  localparam int WAKEUP_CLKSEL_BIT = 5;
  localparam int WAKEUP_IRQEN_BIT = 4;
  localparam int WAKEUP_PERIOD_LSB = 0;

  // ==========================================================
  // Low voltage control fields
  localparam int LV_FLAG_BIT     = 7;
  localparam int LV_CLEAR_BIT    = 6;
  localparam int LV_IRQEN_BIT    = 5;
  localparam int LV_RSTEN_BIT    = 4;
  localparam int LV_STOPEN_BIT   = 3;
  localparam int LV_DETEN_BIT    = 2;
  localparam int LV_BANDGAP_BIT  = 0;

  // ==========================================================
  // Stop power control fields
  localparam int PD_FULL_BIT    = 4;
  localparam int PD_PARTIAL_BIT = 3;
  localparam int PD_CLEAR_BIT   = 2;
  localparam int PD_ENABLE_BIT  = 1;
  localparam int PD_SELECT_BIT  = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] WAKEUP_CTRL_RESET = 8'h00;
  localparam logic [7:0] LV_CTRL_RESET     = 8'h1c;
  localparam logic [7:0] STOP_PWR_RESET    = 8'h00;

  // ==========================================================
  // Timing: 1-kHz tick derived from the 125 MHz bus clock
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_PERIOD_NS  = 1000000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PERIOD_MS_CODE1 = 8;

endpackage

//--- verilog/srp_regs.sv
// System status and control register bank with wakeup timer over APB
//
// Operation
// - High id bits 7:4 read indeterminate (zero here); writes ignored.
// - Fixed part id across high and low id registers, read-only.
// - Wakeup flag bit 7 sets when the periodic timer times out.
// - Writing 1 to bit 6 clears wakeup flag; 0 no effect; reads 0.
// - Bit 5 selects wakeup clock: 0 internal 1 kHz, 1 external.
// - Bit 4 enables the wakeup interrupt.
// - Period code 000 disables; internal codes give 8 ms to 1.024 s.
// - External codes give 256 to 32768 external periods; 000 disables.
// - First timeout may be up to one 1 kHz period short.
// - Low voltage flag sets on detect only while detector enabled.
// - Writing 1 to bit 6 clears low voltage flag; reads 0.
// - Bit 5 set requests interrupt while low voltage flag is 1.
// - Write-once bit 4 forces reset when flag sets, detector enabled.
// - Bit 3 keeps detection in stop mode, only with detector enabled.
// - Write-once bit 2 enables detect logic, qualifying other bits.
// - Bit 0 enables the bandgap reference buffer.
// - Write-once bits accept only the first write after reset.
// - Bits 4 and 3 flag recovery from full and partial power-down.
// - Writing 1 to bit 2 clears both recovery flags.
// - Bit 1 enables entry into power-down stop modes.
// - Bit 0 selects full (0) or partial (1) power-down stop.
module srp_regs #(
  parameter logic [11:0] PART_ID = 12'h5a3  // Arbitrary identification value
) (
  // APB slave
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0]  pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Analog and clock inputs from outside the domain
  input  wire  logic        ext_clk,
  input  wire  logic        low_voltage_detect,
  input  wire  logic        stop_mode,
  input  wire  logic        full_powerdown_exit,
  input  wire  logic        partial_powerdown_exit,
  // Status and control outputs
  output logic              wakeup_irq,
  output logic              low_voltage_irq,
  output logic              low_voltage_reset,
  output logic              bandgap_buffer_enable,
  output logic              powerdown_enable,
  output logic              partial_powerdown_select,
  output logic              detect_active
);

  // ==========================================================
  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic        sel_wk;
  logic        sel_lv;
  logic        sel_pd;
  logic        hit;
  logic [7:0]  wbyte;

  // Writes land at the access edge; read data is captured at the setup edge
  assign wr_en  = psel && penable && pwrite && pready;
  assign rd_en  = psel && !penable && !pwrite;
  assign sel_wk = paddr == srp_pkg::ADDR_WAKEUP_CTRL;
  assign sel_lv = paddr == srp_pkg::ADDR_LOW_VOLT_CTRL;
  assign sel_pd = paddr == srp_pkg::ADDR_STOP_PWR_CTRL;
  assign hit    = sel_wk || sel_lv || sel_pd ||
                  paddr == srp_pkg::ADDR_PART_ID_HIGH ||
                  paddr == srp_pkg::ADDR_PART_ID_LOW;
  assign wbyte  = pstrb[0] ? pwdata[7:0] : 8'h00;

  // Written byte lane present
  logic lane0;
  assign lane0 = pstrb[0];

  // ==========================================================
  // Synchronisers for pins and external clock
  logic [1:0] ext_sync_q;
  logic [1:0] lvd_sync_q;
  logic [1:0] stop_sync_q;
  logic [1:0] fpd_sync_q;
  logic [1:0] ppd_sync_q;
  logic       ext_prev_q;

  // Two flops on every asynchronous input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q  <= 2'h0;
      lvd_sync_q  <= 2'h0;
      stop_sync_q <= 2'h0;
      fpd_sync_q  <= 2'h0;
      ppd_sync_q  <= 2'h0;
      ext_prev_q  <= 1'b0;
    end else begin
      ext_sync_q  <= {ext_sync_q[0], ext_clk};
      lvd_sync_q  <= {lvd_sync_q[0], low_voltage_detect};
      stop_sync_q <= {stop_sync_q[0], stop_mode};
      fpd_sync_q  <= {fpd_sync_q[0], full_powerdown_exit};
      ppd_sync_q  <= {ppd_sync_q[0], partial_powerdown_exit};
      ext_prev_q  <= ext_sync_q[1];
    end
  end

  // Edge detect on the synchronised clock; the history flop resets low,
  // the idle level of the pin, so releasing reset makes no false edge
  logic ext_tick;
  assign ext_tick = ext_sync_q[1] && !ext_prev_q;

  // ==========================================================
  // 1 kHz tick divider, free running
  logic [16:0] div_q;
  logic        ms_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 17'h00000;
    end else if (div_q == 17'(srp_pkg::TICK_CYCLES - 1)) begin
      div_q <= 17'h00000;
    end else begin
      div_q <= div_q + 17'h00001;
    end
  end
  // One-cycle enable at the divider's terminal count
  assign ms_tick = div_q == 17'(srp_pkg::TICK_CYCLES - 1);

  // ==========================================================
  // Wakeup control register
  logic       wk_flag_q;
  logic       wk_clksel_q;
  logic       wk_irqen_q;
  logic [2:0] wk_period_q;
  logic       wk_timeout;

  // Control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_clksel_q <= srp_pkg::WAKEUP_CTRL_RESET[srp_pkg::WAKEUP_CLKSEL_BIT];
      wk_irqen_q  <= srp_pkg::WAKEUP_CTRL_RESET[srp_pkg::WAKEUP_IRQEN_BIT];
      wk_period_q <= srp_pkg::WAKEUP_CTRL_RESET[2:0];
    end else if (wr_en && sel_wk && lane0) begin
      wk_clksel_q <= wbyte[srp_pkg::WAKEUP_CLKSEL_BIT];
      wk_irqen_q  <= wbyte[srp_pkg::WAKEUP_IRQEN_BIT];
      wk_period_q <= wbyte[srp_pkg::WAKEUP_PERIOD_LSB +: 3];
    end
  end

  // Flag: timeout sets, write of 1 clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_flag_q <= 1'b0;
    end else if (wk_timeout) begin
      wk_flag_q <= 1'b1;
    end else if (wr_en && sel_wk && wbyte[srp_pkg::WAKEUP_CLEAR_BIT]) begin
      wk_flag_q <= 1'b0;
    end
  end

  // Terminal count for the selected clock and code
  function automatic logic [15:0] srp_period_count(input logic [2:0] code,
                                                   input logic       ext);
    logic [15:0] n;
    n = 16'h0000;
    if (ext) begin
      unique case (code)
        3'h1:    n = 16'h00ff;
        3'h2:    n = 16'h03ff;
        3'h3:    n = 16'h07ff;
        3'h4:    n = 16'h0fff;
        3'h5:    n = 16'h1fff;
        3'h6:    n = 16'h3fff;
        3'h7:    n = 16'h7fff;
        default: n = 16'h0000;
      endcase
    end else begin
      unique case (code)
        3'h1:    n = 16'(srp_pkg::PERIOD_MS_CODE1 - 1);
        3'h2:    n = 16'h001f;
        3'h3:    n = 16'h003f;
        3'h4:    n = 16'h007f;
        3'h5:    n = 16'h00ff;
        3'h6:    n = 16'h01ff;
        3'h7:    n = 16'h03ff;
        default: n = 16'h0000;
      endcase
    end
    return n;
  endfunction

  // Period counter; restarts on any config write, so first period
  // may be short by part of a 1 kHz tick
  logic [15:0] wk_cnt_q;
  logic        wk_step;
  assign wk_step    = wk_clksel_q ? ext_tick : ms_tick;
  assign wk_timeout = (wk_period_q != 3'h0) && wk_step &&
                      (wk_cnt_q >= srp_period_count(wk_period_q, wk_clksel_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_period_q == 3'h0 || (wr_en && sel_wk)) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_timeout) begin
      wk_cnt_q <= 16'h0000;
    end else if (wk_step) begin
      wk_cnt_q <= wk_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Low voltage control register
  logic lv_flag_q;
  logic lv_irqen_q;
  logic lv_rsten_q;
  logic lv_stopen_q;
  logic lv_deten_q;
  logic lv_bandgap_q;
  logic lv_once_q;
  logic lv_sense;

  // Write-once bits latch on the first write only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_once_q  <= 1'b0;
      lv_rsten_q <= srp_pkg::LV_CTRL_RESET[srp_pkg::LV_RSTEN_BIT];
      lv_deten_q <= srp_pkg::LV_CTRL_RESET[srp_pkg::LV_DETEN_BIT];
    end else if (wr_en && sel_lv && lane0 && !lv_once_q) begin
      lv_once_q  <= 1'b1;
      lv_rsten_q <= wbyte[srp_pkg::LV_RSTEN_BIT];
      lv_deten_q <= wbyte[srp_pkg::LV_DETEN_BIT];
    end
  end

  // Ordinary read/write bits; bit 1 is reserved and not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_irqen_q   <= srp_pkg::LV_CTRL_RESET[srp_pkg::LV_IRQEN_BIT];
      lv_stopen_q  <= srp_pkg::LV_CTRL_RESET[srp_pkg::LV_STOPEN_BIT];
      lv_bandgap_q <= srp_pkg::LV_CTRL_RESET[srp_pkg::LV_BANDGAP_BIT];
    end else if (wr_en && sel_lv && lane0) begin
      lv_irqen_q   <= wbyte[srp_pkg::LV_IRQEN_BIT];
      lv_stopen_q  <= wbyte[srp_pkg::LV_STOPEN_BIT];
      lv_bandgap_q <= wbyte[srp_pkg::LV_BANDGAP_BIT];
    end
  end

  // Detection live when enabled, and in stop only if stop enable set
  assign lv_sense = lv_deten_q && (!stop_sync_q[1] || lv_stopen_q);

  // Flag: detect sets (set wins), write 1 clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_flag_q <= 1'b0;
    end else if (lv_sense && lvd_sync_q[1]) begin
      lv_flag_q <= 1'b1;
    end else if (wr_en && sel_lv && wbyte[srp_pkg::LV_CLEAR_BIT]) begin
      lv_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Stop power control register
  logic pd_full_q;
  logic pd_partial_q;
  logic pd_enable_q;
  logic pd_select_q;
  logic pd_once_q;

  // Power-down enable and mode select, write-once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_once_q   <= 1'b0;
      pd_enable_q <= srp_pkg::STOP_PWR_RESET[srp_pkg::PD_ENABLE_BIT];
      pd_select_q <= srp_pkg::STOP_PWR_RESET[srp_pkg::PD_SELECT_BIT];
    end else if (wr_en && sel_pd && lane0 && !pd_once_q) begin
      pd_once_q   <= 1'b1;
      pd_enable_q <= wbyte[srp_pkg::PD_ENABLE_BIT];
      pd_select_q <= wbyte[srp_pkg::PD_SELECT_BIT];
    end
  end

  // Recovery flags: exit events set, acknowledge clears both
  // Exit pulses must outlast one clock to pass the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_full_q    <= 1'b0;
      pd_partial_q <= 1'b0;
    end else begin
      if (fpd_sync_q[1]) begin
        pd_full_q <= 1'b1;
      end else if (wr_en && sel_pd && wbyte[srp_pkg::PD_CLEAR_BIT]) begin
        pd_full_q <= 1'b0;
      end
      if (ppd_sync_q[1]) begin
        pd_partial_q <= 1'b1;
      end else if (wr_en && sel_pd && wbyte[srp_pkg::PD_CLEAR_BIT]) begin
        pd_partial_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data mux
  function automatic logic [7:0] srp_read(input logic [7:0] a,
                                          input logic [7:0] wk,
                                          input logic [7:0] lv,
                                          input logic [7:0] pd);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      srp_pkg::ADDR_PART_ID_HIGH:  r = {4'h0, PART_ID[11:8]};
      srp_pkg::ADDR_PART_ID_LOW:   r = PART_ID[7:0];
      srp_pkg::ADDR_WAKEUP_CTRL:   r = wk;
      srp_pkg::ADDR_LOW_VOLT_CTRL: r = lv;
      srp_pkg::ADDR_STOP_PWR_CTRL: r = pd;
      default:                     r = 8'h00;
    endcase
    return r;
  endfunction

  logic [7:0] wk_view;
  logic [7:0] lv_view;
  logic [7:0] pd_view;
  // Acknowledge bits always read 0
  assign wk_view = {wk_flag_q, 1'b0, wk_clksel_q, wk_irqen_q, 1'b0, wk_period_q};
  assign lv_view = {lv_flag_q, 1'b0, lv_irqen_q, lv_rsten_q,
                    lv_stopen_q, lv_deten_q, 1'b0, lv_bandgap_q};
  assign pd_view = {3'h0, pd_full_q, pd_partial_q, 1'b0, pd_enable_q, pd_select_q};

  // APB answer: no wait states, data registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) begin
        prdata <= {24'h000000, srp_read(paddr, wk_view, lv_view, pd_view)};
      end
    end
  end

  // ==========================================================
  // Registered status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_irq               <= 1'b0;
      low_voltage_irq          <= 1'b0;
      low_voltage_reset        <= 1'b0;
      bandgap_buffer_enable    <= 1'b0;
      powerdown_enable         <= 1'b0;
      partial_powerdown_select <= 1'b0;
      detect_active            <= 1'b0;
    end else begin
      wakeup_irq               <= wk_flag_q && wk_irqen_q;
      low_voltage_irq          <= lv_flag_q && lv_irqen_q;
      low_voltage_reset        <= lv_flag_q && lv_rsten_q && lv_deten_q;
      bandgap_buffer_enable    <= lv_bandgap_q;
      powerdown_enable         <= pd_enable_q;
      partial_powerdown_select <= pd_select_q;
      detect_active            <= lv_sense;
    end
  end

endmodule

//--- dv/srp_regs_properties.sv
// Checker: bus timing, id values and control pin relations of the register bank
module srp_regs_checker #(
  parameter logic [11:0] PART_ID = 12'h5a3  // Arbitrary identification value
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Outputs watched
  input wire logic        wakeup_irq,
  input wire logic        low_voltage_irq,
  input wire logic        bandgap_buffer_enable,
  input wire logic        powerdown_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================
  // Helper logic
  logic wr_any;
  logic rd_done;
  logic pd_seen_q;
  // Completed writes with byte lane 0 and completed reads
  assign wr_any  = psel && penable && pready && pwrite && pstrb[0];
  assign rd_done = psel && penable && pready && !pwrite;

  // Marks that the stop power register has had its first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_seen_q <= 1'b0;
    end else if (wr_any && paddr == srp_pkg::ADDR_STOP_PWR_CTRL) begin
      pd_seen_q <= 1'b1;
    end
  end

  // ==========================================
  // Properties
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence

  a_ready_pulse: assert property (s_setup |=> s_pulse)
    else $error("pready is not a one cycle answer");
  a_unmapped_err: assert property (s_setup ##0 paddr > 8'h10 |=> pready && pslverr)
    else $error("unmapped access without error");
  a_id_high: assert property (
    rd_done && paddr == srp_pkg::ADDR_PART_ID_HIGH |-> prdata == {28'h0, PART_ID[11:8]})
    else $error("high id read wrong");
  a_id_low: assert property (
    rd_done && paddr == srp_pkg::ADDR_PART_ID_LOW |-> prdata == {24'h0, PART_ID[7:0]})
    else $error("low id read wrong");
  a_ack_reads_zero: assert property (
    rd_done && (paddr == srp_pkg::ADDR_WAKEUP_CTRL || paddr == srp_pkg::ADDR_LOW_VOLT_CTRL)
    |-> !prdata[6])
    else $error("clear bit read as one");
  a_wake_irq_off: assert property (
    wr_any && paddr == srp_pkg::ADDR_WAKEUP_CTRL && (pwdata[6] || !pwdata[4])
    |-> ##2 !wakeup_irq)
    else $error("wakeup irq stays after clear or disable");
  a_lv_irq_off: assert property (
    wr_any && paddr == srp_pkg::ADDR_LOW_VOLT_CTRL && !pwdata[5] |-> ##2 !low_voltage_irq)
    else $error("low voltage irq stays while disabled");
  a_bandgap_follow: assert property (
    wr_any && paddr == srp_pkg::ADDR_LOW_VOLT_CTRL
    |-> ##2 bandgap_buffer_enable == $past(pwdata[0], 2))
    else $error("bandgap enable does not follow write");
  a_pd_locked: assert property (
    wr_any && paddr == srp_pkg::ADDR_STOP_PWR_CTRL && pd_seen_q
    |-> ##2 powerdown_enable == $past(powerdown_enable, 2))
    else $error("power-down enable changed after first write");
endmodule

bind srp_regs srp_regs_checker #(.PART_ID(PART_ID)) i_srp_regs_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
  .pslverr, .wakeup_irq, .low_voltage_irq, .bandgap_buffer_enable, .powerdown_enable
);

//--- dv/tb_top.sv
// Testbench: ids, wakeup timer, low voltage and stop power through APB
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] PART_ID = 12'h5a3;  // Arbitrary identification value
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, ext_clk, low_voltage_detect, stop_mode;
  logic        full_powerdown_exit, partial_powerdown_exit, pready, pslverr;
  logic        wakeup_irq, low_voltage_irq, low_voltage_reset, bandgap_buffer_enable;
  logic        powerdown_enable, partial_powerdown_select, detect_active;
  logic [7:0]  paddr, ctrl, bg;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [32:0] exp_q[$];
  logic [7:0]  lfsr_q = 8'h4f;
  logic [7:0]  rst_tab[5];
  int          prd[4] = '{300, 256, 1024, 2048};
  int          err_count = 0;
  int          total_checks = 0;

  srp_regs #(.PART_ID(PART_ID)) i_srp_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .ext_clk, .low_voltage_detect, .stop_mode, .full_powerdown_exit,
    .partial_powerdown_exit, .wakeup_irq, .low_voltage_irq, .low_voltage_reset,
    .bandgap_buffer_enable, .powerdown_enable, .partial_powerdown_select, .detect_active
  );

  always #4 pclk = ~pclk;

  // ==========================================
  // Helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch read exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask

  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {lfsr_q, 16'h0000, d};
    pstrb <= w ? 4'h1 : 4'h0;
    lfsr_q = lfsr_next(lfsr_q);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Request stands until the edge that samples pready high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      $display("mismatch pready exp 1 got %b", pready);
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back({(a > 8'h10), 24'h0, d});
    apb(1'b0, a, 8'h00);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Read results are compared against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      cmp_reg(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, ext_clk, low_voltage_detect, stop_mode} = '0;
    {full_powerdown_exit, partial_powerdown_exit} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    rst_tab = '{{4'h0, PART_ID[11:8]}, PART_ID[7:0], srp_pkg::WAKEUP_CTRL_RESET,
                srp_pkg::LV_CTRL_RESET, srp_pkg::STOP_PWR_RESET};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_tab[i]) rd(8'(4 * i), rst_tab[i]);
    apb(1'b1, srp_pkg::ADDR_PART_ID_HIGH, 8'hff);
    apb(1'b1, srp_pkg::ADDR_PART_ID_LOW, 8'h00);
    rd(srp_pkg::ADDR_PART_ID_HIGH, rst_tab[0]);
    rd(srp_pkg::ADDR_PART_ID_LOW, rst_tab[1]);
    rd(8'h14, 8'h00);
    // Wakeup timer on external clock, codes 0 to 3
    for (int c = 0; c < 4; c++) begin
      ctrl = 8'h20 | 8'(c) | (c[0] ? 8'h10 : 8'h00);
      apb(1'b1, srp_pkg::ADDR_WAKEUP_CTRL, ctrl);
      ext_pulses(prd[c] - 1);
      wait_cyc(4);
      cmp_pin("wakeup_irq", 1'b0, wakeup_irq);
      ext_pulses(1);
      wait_cyc(6);
      cmp_pin("wakeup_irq", c[0], wakeup_irq);
      rd(srp_pkg::ADDR_WAKEUP_CTRL, ctrl | ((c != 0) ? 8'h80 : 8'h00));
      apb(1'b1, srp_pkg::ADDR_WAKEUP_CTRL, ctrl | 8'h40);
      rd(srp_pkg::ADDR_WAKEUP_CTRL, ctrl);
    end
    // Internal clock selected: external edges must not advance the timer
    apb(1'b1, srp_pkg::ADDR_WAKEUP_CTRL, 8'h11);
    ext_pulses(300);
    cmp_pin("wakeup_irq", 1'b0, wakeup_irq);
    rd(srp_pkg::ADDR_WAKEUP_CTRL, 8'h11);
    // Low voltage detect, write-once lock and stop gating
    low_voltage_detect <= 1'b1;
    wait_cyc(6);
    cmp_pin("low_voltage_reset", 1'b1, low_voltage_reset);
    cmp_pin("low_voltage_irq", 1'b0, low_voltage_irq);
    low_voltage_detect <= 1'b0;
    bg = {7'h0, lfsr_q[0]};
    apb(1'b1, srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h64 | bg);
    rd(srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h24 | bg);
    cmp_pin("bandgap_buffer_enable", bg[0], bandgap_buffer_enable);
    cmp_pin("low_voltage_reset", 1'b0, low_voltage_reset);
    apb(1'b1, srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h1c);
    rd(srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h0c);
    stop_mode <= 1'b1;
    wait_cyc(4);
    cmp_pin("detect_active", 1'b1, detect_active);
    apb(1'b1, srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h04);
    wait_cyc(4);
    cmp_pin("detect_active", 1'b0, detect_active);
    stop_mode <= 1'b0;
    apb(1'b1, srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h24);
    low_voltage_detect <= 1'b1;
    wait_cyc(6);
    cmp_pin("low_voltage_irq", 1'b1, low_voltage_irq);
    cmp_pin("low_voltage_reset", 1'b0, low_voltage_reset);
    rd(srp_pkg::ADDR_LOW_VOLT_CTRL, 8'ha4);
    low_voltage_detect <= 1'b0;
    apb(1'b1, srp_pkg::ADDR_LOW_VOLT_CTRL, 8'h64);
    wait_cyc(3);
    cmp_pin("low_voltage_irq", 1'b0, low_voltage_irq);
    // Stop power controls and recovery flags
    apb(1'b1, srp_pkg::ADDR_STOP_PWR_CTRL, 8'h03);
    apb(1'b1, srp_pkg::ADDR_STOP_PWR_CTRL, 8'h00);
    rd(srp_pkg::ADDR_STOP_PWR_CTRL, 8'h03);
    cmp_pin("powerdown_enable", 1'b1, powerdown_enable);
    cmp_pin("partial_powerdown_select", 1'b1, partial_powerdown_select);
    full_powerdown_exit <= 1'b1;
    wait_cyc(4);
    full_powerdown_exit <= 1'b0;
    partial_powerdown_exit <= 1'b1;
    wait_cyc(4);
    partial_powerdown_exit <= 1'b0;
    wait_cyc(4);
    rd(srp_pkg::ADDR_STOP_PWR_CTRL, 8'h1b);
    apb(1'b1, srp_pkg::ADDR_STOP_PWR_CTRL, 8'h04);
    rd(srp_pkg::ADDR_STOP_PWR_CTRL, 8'h03);
    // Mid-run reset reopens the write-once lock
    presetn <= 1'b0;
    wait_cyc(2);
    presetn <= 1'b1;
    apb(1'b1, srp_pkg::ADDR_STOP_PWR_CTRL, 8'h02);
    rd(srp_pkg::ADDR_STOP_PWR_CTRL, 8'h02);
    cmp_pin("powerdown_enable", 1'b1, powerdown_enable);
    cmp_pin("partial_powerdown_select", 1'b0, partial_powerdown_select);
    wait_cyc(4);
    wrap_up();
  end
endmodule
